// File: seep_bus_master.sv
// two-wire bus master model for the serial eeprom core, behavioural
// assumes the bench resolves the open-drain data wire with a pull-up
module seep_bus_master #(
    parameter int QUARTER = 20
) (
    input wire logic clock,
    input wire logic sdaWire,
    output logic sclLine,
    output logic masterLow
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock parked high, data released
    initial begin
        sclLine = 1'b1;
        masterLow = 1'b0;
    end
    // quarter bit; every change lands on a falling core edge
    task automatic quarter();
        repeat (QUARTER) @(negedge clock);
    endtask
    // data falls while clock high; also serves as repeated start
    task automatic start_cond();
        masterLow = 1'b0;
        quarter();
        sclLine = 1'b1;
        quarter();
        masterLow = 1'b1;
        quarter();
        sclLine = 1'b0;
        quarter();
    endtask
    // data rises while clock high, clock then stands still
    task automatic stop_cond();
        masterLow = 1'b1;
        quarter();
        sclLine = 1'b1;
        quarter();
        masterLow = 1'b0;
        quarter();
    endtask
    // one clock pulse; wire sampled mid-high, well after the device drive settles
    task automatic put_bit(input logic b, output logic seen);
        masterLow = !b;
        quarter();
        sclLine = 1'b1;
        quarter();
        seen = sdaWire;
        quarter();
        sclLine = 0;
        quarter();
    endtask
    task automatic send_byte(input logic [7:0] value, output logic ackSeen);
        logic dummy;
        for (int i = 7; i >= 0; i--) put_bit(value[i], dummy);
        put_bit(1'b1, ackSeen);
    endtask
    task automatic get_byte(input logic ackIt, output logic [7:0] value);
        logic dummy;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, value[i]);
        put_bit(!ackIt, dummy);
    endtask
endmodule // seep_bus_master

// File: seep_core.sv
// serial eeprom slave core: two-wire link side, page buffer, array, programming timer
// assumes sda/scl/straps arrive raw from pins; the link clock runs freely and oversamples scl
module seep_core #(
    parameter int ADDR_W = seep_pkg::MEM_ADDR_W,
    parameter int PAGE_W = seep_pkg::PAGE_ADDR_W,
    parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic linkClock,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic [2:0] chipSelectStraps,
    output logic sdaOut,
    output logic sdaOe,
    output logic programBusy
);
    import seep_pkg::*;

    // address bits that the address byte carries as block select
    localparam int BLK_W = (ADDR_W > 8) ? ADDR_W - 8 : 0;
    localparam int PAGE_N = 1 << PAGE_W;
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    // link-domain state
    typedef struct packed {
        logic [2:0] sclQ; // two sync stages, then previous
        logic [2:0] sdaQ;
        logic [2:0] strapQ; // first sync stage of straps
        logic [2:0] straps;
        logic [1:0] busyQ; // busy from core domain
        seep_state_e state;
        seep_kind_e kind;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic isRead;
        logic [2:0] blk;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_N-1:0] pageValid;
        logic wrAny; // page holds unsent bytes
        logic pend; // programming under way, link deaf
        logic seenBusy;
        logic progTog; // event toward core domain
        logic commitOn;
        logic [PAGE_W-1:0] commitIdx;
        logic sdaOe;
        logic sdaOut;
    } seep_link_s;

    // core-domain state
    typedef struct packed {
        logic [2:0] togQ; // two sync stages, then previous
        logic busy;
        logic [CNT_W-1:0] cnt;
    } seep_sys_s;

    seep_link_s l, next_l;
    seep_sys_s s, next_s;
    logic [1:0] linkRstQ; // reset synchroniser for the link side
    logic linkRst;
    logic [7:0] mem [0:(1 << ADDR_W) - 1]; // the array itself
    logic [7:0] pageMem [0:PAGE_N - 1]; // page buffer
    logic [7:0] memRd;
    logic pageWr;
    logic doLoad;
    logic rise, fall, sclHi, startEv, stopEv, rxDone;
    logic [PAGE_W-1:0] addrLo;
    logic [ADDR_W-PAGE_W-1:0] addrHi;

    // strap check on the address bits not used as block select
    function automatic logic strapOk(input logic [2:0] sel, input logic [2:0] pins);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (i >= BLK_W && sel[i] != pins[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // assert asynchronously, release on the link clock
    always_ff @(posedge linkClock or posedge sys_rst) begin
        if (sys_rst) begin
            linkRstQ <= 2'h3;
        end else begin
            linkRstQ <= {linkRstQ[0], 1'b0};
        end
    end
    assign linkRst = linkRstQ[1];

    // bus events from the synchronised lines only
    assign sclHi = l.sclQ[1] & l.sclQ[2];
    assign rise = l.sclQ[1] & ~l.sclQ[2];
    assign fall = ~l.sclQ[1] & l.sclQ[2];
    assign startEv = sclHi & l.sdaQ[2] & ~l.sdaQ[1];
    assign stopEv = sclHi & ~l.sdaQ[2] & l.sdaQ[1];
    assign rxDone = (l.state == ST_RX) && fall && (l.bitCnt == BYTE_BITS) && !l.pend;
    assign memRd = mem[l.addr];
    assign addrLo = l.addr[PAGE_W-1:0];
    assign addrHi = l.addr[ADDR_W-1:PAGE_W];

    // link sequencer next state
    always_comb begin
        next_l = l;
        pageWr = 1'b0;
        doLoad = 1'b0;
        next_l.sclQ = {l.sclQ[1:0], sclIn};
        next_l.sdaQ = {l.sdaQ[1:0], sdaIn};
        next_l.strapQ = chipSelectStraps;
        next_l.straps = l.strapQ;
        next_l.busyQ = {l.busyQ[0], s.busy};
        // handshake back: pend ends only after busy was seen and dropped
        if (l.pend && l.busyQ[1]) begin
            next_l.seenBusy = 1'b1;
        end
        if (l.pend && l.seenBusy && !l.busyQ[1] && !l.commitOn) begin
            next_l.pend = 1'b0;
            next_l.seenBusy = 1'b0;
        end
        if (l.commitOn) begin
            next_l.commitIdx = l.commitIdx + 1'b1;
            if (&l.commitIdx) begin
                next_l.commitOn = 1'b0;
                next_l.pageValid = '0;
            end
        end
        if (l.pend) begin
            next_l.state = ST_IDLE;
            next_l.sdaOe = 1'b0;
        end else if (startEv) begin
            // start or repeated start: expect address byte
            next_l.state = ST_RX;
            next_l.kind = K_DEV;
            next_l.bitCnt = '0;
            next_l.sdaOe = 1'b0;
        end else if (stopEv) begin
            next_l.state = ST_IDLE;
            next_l.sdaOe = 1'b0;
            if (l.wrAny) begin
                next_l.pend = 1'b1;
                next_l.progTog = ~l.progTog;
                next_l.commitOn = 1'b1;
                next_l.commitIdx = '0;
                next_l.wrAny = 1'b0;
            end
        end else begin
            case (l.state)
                ST_RX: begin
                    // sample on the rising edge, hold off at eight bits
                    if (rise && l.bitCnt != BYTE_BITS) begin
                        next_l.shift = {l.shift[6:0], l.sdaQ[1]};
                        next_l.bitCnt = l.bitCnt + 1'b1;
                    end
                    if (rxDone) begin
                        next_l.sdaOe = 1'b1;
                        next_l.state = ST_ACKO;
                        case (l.kind)
                            K_DEV: begin
                                if (l.shift[7:4] == DEV_TYPE && strapOk(l.shift[3:1], l.straps)) begin
                                    next_l.isRead = l.shift[0];
                                    next_l.blk = l.shift[3:1];
                                end else begin
                                    next_l.sdaOe = 1'b0;
                                    next_l.state = ST_IDLE;
                                end
                            end
                            K_WORD: begin
                                next_l.addr = ADDR_W'({l.blk, l.shift});
                            end
                            default: begin
                                pageWr = 1'b1;
                                next_l.pageValid[addrLo] = 1'b1;
                                next_l.wrAny = 1'b1;
                                next_l.addr = {addrHi, PAGE_W'(addrLo + 1'b1)};
                            end
                        endcase
                    end
                end
                ST_ACKO: begin
                    // end of ninth clock: read sends, write listens again
                    // read address byte starts the data
                    if (fall) begin
                        if (l.isRead) begin
                            doLoad = 1'b1;
                        end else begin
                            next_l.sdaOe = 1'b0;
                            next_l.state = ST_RX;
                            next_l.bitCnt = '0;
                            next_l.kind = (l.kind == K_DEV) ? K_WORD : K_DATA;
                        end
                    end
                end
                ST_TX: begin
                    // change data while scl is low
                    if (fall) begin
                        if (l.bitCnt == LAST_BIT) begin
                            next_l.sdaOe = 1'b0;
                            next_l.state = ST_ACKI;
                            next_l.bitCnt = '0;
                        end else begin
                            next_l.shift = {l.shift[6:0], 1'b0};
                            next_l.sdaOe = ~l.shift[6];
                            next_l.bitCnt = l.bitCnt + 1'b1;
                        end
                    end
                end
                ST_ACKI: begin
                    if (rise) begin
                        if (!l.sdaQ[1]) begin
                            next_l.bitCnt = BYTE_BITS;
                        end else begin
                            next_l.state = ST_IDLE;
                        end
                    end
                    if (fall && l.bitCnt == BYTE_BITS) begin
                        doLoad = 1'b1;
                    end
                end
                default: begin
                    next_l.sdaOe = 1'b0;
                end
            endcase
            if (doLoad) begin
                next_l.shift = memRd;
                next_l.addr = l.addr + 1'b1;
                next_l.sdaOe = ~memRd[7];
                next_l.bitCnt = '0;
                next_l.state = ST_TX;
            end
        end
    end

    // link-domain registers
    always_ff @(posedge linkClock or posedge linkRst) begin
        if (linkRst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // page buffer and array; no reset, contents are data
    always_ff @(posedge linkClock) begin
        if (pageWr) begin
            pageMem[addrLo] <= l.shift;
        end
        if (l.commitOn && l.pageValid[l.commitIdx]) begin
            mem[{addrHi, l.commitIdx}] <= pageMem[l.commitIdx];
        end
    end

    // programming timer next state
    always_comb begin
        next_s = s;
        next_s.togQ = {s.togQ[1:0], l.progTog};
        if (s.togQ[2] != s.togQ[1]) begin
            next_s.busy = 1'b1;
            next_s.cnt = CNT_W'(PROG_CYCLES - 1);
        end else if (s.busy) begin
            if (s.cnt == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.cnt = s.cnt - 1'b1;
            end
        end
    end

    // core-domain registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sdaOut = l.sdaOut;
    assign sdaOe = l.sdaOe;
    assign programBusy = s.busy;

    // checks
    property p_ackData;
        @(posedge linkClock) disable iff (linkRst)
        rxDone && l.kind == K_DATA |=> l.sdaOe && l.state == ST_ACKO;
    endproperty
    a_ackData: assert property (p_ackData) else $error("data byte not acknowledged");
    property p_pageWrap;
        @(posedge linkClock) disable iff (linkRst)
        rxDone && l.kind == K_DATA |=> addrHi == $past(addrHi) && addrLo == PAGE_W'($past(addrLo) + 1);
    endproperty
    a_pageWrap: assert property (p_pageWrap) else $error("page address step wrong");
    property p_commit;
        @(posedge linkClock) disable iff (linkRst)
        stopEv && !l.pend && l.wrAny |=> l.pend && l.commitOn;
    endproperty
    a_commit: assert property (p_commit) else $error("stop did not start programming");
    property p_deaf;
        @(posedge linkClock) disable iff (linkRst)
        l.pend |=> !l.sdaOe && l.state == ST_IDLE;
    endproperty
    a_deaf: assert property (p_deaf) else $error("line driven while programming");
    property p_nack;
        @(posedge linkClock) disable iff (linkRst)
        rxDone && l.kind == K_DEV && l.shift[7:4] != DEV_TYPE |=> !l.sdaOe && l.state == ST_IDLE;
    endproperty
    a_nack: assert property (p_nack) else $error("foreign address acknowledged");
    property p_load;
        @(posedge linkClock) disable iff (linkRst)
        doLoad |=> l.shift == $past(memRd) && l.addr == ADDR_W'($past(l.addr) + 1) && l.state == ST_TX;
    endproperty
    a_load: assert property (p_load) else $error("read byte or counter wrong");
    property p_wrap;
        @(posedge linkClock) disable iff (linkRst)
        doLoad && (&l.addr) |=> l.addr == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
    property p_release;
        @(posedge linkClock) disable iff (linkRst)
        l.state == ST_ACKI && rise && l.sdaQ[1] && !l.pend && !startEv |=> !l.sdaOe ##1 !l.sdaOe;
    endproperty
    a_release: assert property (p_release) else $error("line held after master nack");
    property p_busyStart;
        @(posedge clock) disable iff (sys_rst)
        s.togQ[2] != s.togQ[1] |=> s.busy && s.cnt == CNT_W'(PROG_CYCLES - 1);
    endproperty
    a_busyStart: assert property (p_busyStart) else $error("busy window not loaded");
    property p_busyHold;
        @(posedge clock) disable iff (sys_rst)
        s.busy && s.cnt != '0 |=> s.busy && s.cnt == CNT_W'($past(s.cnt) - 1);
    endproperty
    a_busyHold: assert property (p_busyHold) else $error("busy dropped early");
    c_pageCommit: cover property (@(posedge linkClock) disable iff (linkRst) stopEv && l.wrAny);
    c_seqRead: cover property (@(posedge linkClock) disable iff (linkRst)
        doLoad && l.state == ST_ACKI);
    c_pollBusy: cover property (@(posedge linkClock) disable iff (linkRst) l.pend && startEv);
endmodule // seep_core

// File: seep_pkg.sv
// package for the serial eeprom slave core: device pattern, sizes, timing, encodings
// assumes the core clock runs at 125 MHz and the link clock is free-running
package seep_pkg;
    // fixed device-type pattern in the address byte
    localparam logic [3:0] DEV_TYPE = 4'hA;
    // largest variant: 2048 bytes, 16-byte pages
    localparam int MEM_ADDR_W = 32'h0000_000B;
    localparam int PAGE_ADDR_W = 32'h0000_0004;
    // bits in one byte slot before the ninth clock
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // self-timed programming cycle
    localparam int CLK_PERIOD_NS = 32'h0000_0008;
    localparam int WRITE_CYCLE_NS = 32'h004C_4B40;
    // longest time, so integer division rounds down
    localparam int PROG_CYCLES_DEF = WRITE_CYCLE_NS / CLK_PERIOD_NS;
    // link-side sequencer, gray along idle-rx-ack-tx-ack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACKO = 3'h3,
        ST_TX = 3'h2,
        ST_ACKI = 3'h6
    } seep_state_e;
    // which byte of a frame is being received
    typedef enum logic [1:0] {
        K_DEV = 2'h0,
        K_WORD = 2'h1,
        K_DATA = 2'h3
    } seep_kind_e;
endpackage

// File: testbench.sv
// self-checking bench for the serial eeprom core with a bus master model
// assumes the core package and seep_core; short programming count for speed
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import seep_pkg::*;
    localparam int PROG = 2000; // long enough that polls see busy
    localparam int LIMIT = 100000; // run needs about half of this
    logic clock = 1'b0;
    logic linkClock = 1'b0;
    logic sys_rst = 1'b1;
    logic sclIn, sdaWire, masterLow, sdaOut, sdaOe, programBusy;
    logic [2:0] chipSelectStraps = 3'h5; // unused with eight blocks
    logic [7:0] expMem [0:2047]; // expected array, written places only
    int err_total = 0;
    int checks = 0;
    int cycleCount = 0;
    int busyRun = 0;
    int busyLast = 0;
    // core clock 8 ns
    always #4 clock = ~clock;
    // link clock 48 ns, offset so its phase is unrelated
    initial begin
        #7;
        forever #24 linkClock = ~linkClock;
    end
    // open drain with pull-up
    assign sdaWire = !(masterLow || (sdaOe && !sdaOut));
    seep_core #(
        .PROG_CYCLES(PROG)
    ) dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .linkClock(linkClock),
        .sclIn(sclIn),
        .sdaIn(sdaWire),
        .chipSelectStraps(chipSelectStraps),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .programBusy(programBusy)
    );
    seep_bus_master bm (
        .clock(clock),
        .sdaWire(sdaWire),
        .sclLine(sclIn),
        .masterLow(masterLow)
    );
    // cycle count and length of the last busy run
    always @(posedge clock) begin
        cycleCount <= cycleCount + 1;
        if (programBusy === 1'b1) busyRun <= busyRun + 1;
        else if (busyRun != 0) begin
            busyLast <= busyRun;
            busyRun <= 0;
        end
    end
    // hang guard
    always @(negedge clock) if (cycleCount == LIMIT) begin
        err_total++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    // address byte: type, block bits, direction
    function automatic logic [7:0] dev_byte(input logic [10:0] addr, input logic rd);
        return {DEV_TYPE, addr[10:8], rd};
    endfunction
    // write n bytes from addr; expected array follows the in-page wrap
    // more than a page only on purpose, to reach the wrap
    task automatic page_write(input logic [10:0] addr, input int n, input logic [7:0] base);
        logic ack;
        logic [10:0] at;
        bm.start_cond();
        bm.send_byte(dev_byte(addr, 1'b0), ack);
        check(ack, 1'b0);
        bm.send_byte(addr[7:0], ack);
        check(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            bm.send_byte(base + 8'(i), ack);
            check(ack, 1'b0);
            at = {addr[10:4], addr[3:0] + 4'(i)};
            expMem[at] = base + 8'(i);
        end
        bm.stop_cond();
    endtask
    // poll with write address byte, bounded tries
    task automatic wait_ready(input logic [10:0] addr, input logic expectBusy);
        logic ack;
        int tries;
        tries = 0;
        ack = 1'b1;
        while (ack !== 1'b0 && tries < 12) begin
            bm.start_cond();
            bm.send_byte(dev_byte(addr, 1'b0), ack);
            if (ack !== 1'b0) bm.stop_cond();
            tries++;
        end
        check(ack, 1'b0);
        check(tries > 1, expectBusy);
        if (expectBusy) check(16'(busyLast), 16'(PROG));
    endtask
    // dummy write, then repeated start and n bytes
    task automatic read_from(input logic [10:0] addr, input int n);
        logic ack;
        logic [7:0] got;
        wait_ready(addr, 1'b0);
        bm.send_byte(addr[7:0], ack);
        check(ack, 1'b0);
        bm.start_cond();
        bm.send_byte(dev_byte(addr, 1'b1), ack);
        check(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            bm.get_byte(i < n - 1, got);
            check(got, expMem[addr + 11'(i)]);
        end
        bm.stop_cond();
        check(sdaOe, 1'b0);
    endtask
    task automatic cur_read(input logic [10:0] expAddr);
        logic ack;
        logic [7:0] got;
        bm.start_cond();
        bm.send_byte(dev_byte(11'h000, 1'b1), ack);
        check(ack, 1'b0);
        bm.get_byte(1'b0, got);
        check(got, expMem[expAddr]);
        bm.stop_cond();
    endtask
    // wrong type pattern must stay unanswered
    task automatic test_foreign();
        logic ack;
        bm.start_cond();
        bm.send_byte(8'hB0, ack);
        check(ack, 1'b1);
        bm.stop_cond();
    endtask
    // 18 bytes into a 16-byte page from offset 8: last two overwrite
    task automatic test_page_wrap();
        page_write(11'h308, 18, 8'h40);
        wait_ready(11'h308, 1'b1);
        bm.stop_cond();
        read_from(11'h300, 15);
        cur_read(11'h30F);
    endtask
    // top of array and location zero, single and sequential
    task automatic test_top_wrap();
        page_write(11'h7FF, 1, 8'hC3);
        wait_ready(11'h7FF, 1'b1);
        bm.stop_cond();
        page_write(11'h000, 1, 8'h3C);
        wait_ready(11'h000, 1'b1);
        bm.stop_cond();
        read_from(11'h7FF, 1);
        cur_read(11'h000);
        read_from(11'h7FF, 2);
    endtask
    // reset, then the scenarios
    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        repeat (20) @(negedge clock);
        // open drain: data output stays low, line released, idle timer
        check({sdaOut, sdaOe, programBusy}, 3'b000);
        test_foreign();
        test_page_wrap();
        test_top_wrap();
        end_sim();
    end
endmodule // testbench
